// File: rtl/supervisor_pkg.sv
// Constants shared by the supervisor and watchdog block.
// Assumes a 40 MHz system clock and an AHB-Lite register bus.
package supervisor_pkg;
    // Clock rate and derived cycle count per millisecond
    localparam int unsigned CLK_MHZ    = 40;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;

    // Power-up hold times in milliseconds, one per select code;
    // plain defaults, to be set for the board
    localparam int unsigned HOLD0_MS = 100;
    localparam int unsigned HOLD1_MS = 250;
    localparam int unsigned HOLD2_MS = 500;
    localparam int unsigned HOLD3_MS = 1000;
    localparam int unsigned HOLD0_CYC = HOLD0_MS * CYC_PER_MS;
    localparam int unsigned HOLD1_CYC = HOLD1_MS * CYC_PER_MS;
    localparam int unsigned HOLD2_CYC = HOLD2_MS * CYC_PER_MS;
    localparam int unsigned HOLD3_CYC = HOLD3_MS * CYC_PER_MS;

    // Watchdog periods in milliseconds; select code 3 is off
    localparam int unsigned WD0_MS  = 50;
    localparam int unsigned WD1_MS  = 500;
    localparam int unsigned WD2_MS  = 2000;
    localparam int unsigned WD0_CYC = WD0_MS * CYC_PER_MS;
    localparam int unsigned WD1_CYC = WD1_MS * CYC_PER_MS;
    localparam int unsigned WD2_CYC = WD2_MS * CYC_PER_MS;
    localparam logic [1:0]  WD_OFF  = 2'h3;

    // Widths
    localparam int unsigned CNT_W  = 32;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned OFS_W  = 8;
    localparam int unsigned EV_W   = 3;
    localparam int unsigned PIN_W  = 6;

    // Register byte offsets
    localparam logic [OFS_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [OFS_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [OFS_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [OFS_W-1:0] OFS_IRQ_CLR  = 8'h0C;
    localparam logic [OFS_W-1:0] OFS_IRQ_EN   = 8'h10;

    // Control fields and reset value
    localparam int unsigned CTRL_WD_LSB   = 0;
    localparam int unsigned CTRL_HOLD_LSB = 2;
    localparam int unsigned CTRL_W        = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

    // Event bits of the interrupt registers
    localparam int unsigned EV_RESET = 0;
    localparam int unsigned EV_WDOG  = 1;
    localparam int unsigned EV_THIRD = 2;

    // Synchroniser bit positions and idle levels
    localparam int unsigned PIN_SDA   = 0;
    localparam int unsigned PIN_SCL   = 1;
    localparam int unsigned PIN_LOW   = 2;
    localparam int unsigned PIN_MR_N  = 3;
    localparam int unsigned PIN_THIRD = 4;
    localparam int unsigned PIN_WP    = 5;
    // Idle: bus lines high, supply good, manual reset and protect off
    localparam logic [PIN_W-1:0] PIN_IDLE = 6'h1B;

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int unsigned HTRANS_ACT = 1;

    // Watchdog restart sequence tracker
    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,
        WD_START = 2'b01,
        WD_LOW   = 2'b10,
        WD_HIGH  = 2'b11
    } wd_seq_t;
endpackage : supervisor_pkg

// File: rtl/supervisor_reset_watchdog.sv
// Supervisor: system reset sequencing, bus watchdog, third-supply fail,
// AHB-Lite register slave with sticky interrupt status.
// Assumes comparator outputs and bus pins arrive asynchronous to CLK.
`timescale 1ns/1ps
module supervisor_reset_watchdog #(
    parameter int unsigned HOLD0_CYC = supervisor_pkg::HOLD0_CYC,
    parameter int unsigned HOLD1_CYC = supervisor_pkg::HOLD1_CYC,
    parameter int unsigned HOLD2_CYC = supervisor_pkg::HOLD2_CYC,
    parameter int unsigned HOLD3_CYC = supervisor_pkg::HOLD3_CYC,
    parameter int unsigned WD0_CYC   = supervisor_pkg::WD0_CYC,
    parameter int unsigned WD1_CYC   = supervisor_pkg::WD1_CYC,
    parameter int unsigned WD2_CYC   = supervisor_pkg::WD2_CYC
) (
    // Clock, reset, enable
    input  wire logic                              CLK,
    input  wire logic                              RESET_N,
    input  wire logic                              CE,
    // AHB-Lite slave
    input  wire logic                              HSEL,
    input  wire logic [supervisor_pkg::ADDR_W-1:0] HADDR,
    input  wire logic [1:0]                        HTRANS,
    input  wire logic                              HWRITE,
    input  wire logic [2:0]                        HSIZE,
    input  wire logic [supervisor_pkg::DATA_W-1:0] HWDATA,
    input  wire logic                              HREADY,
    output logic      [supervisor_pkg::DATA_W-1:0] HRDATA,
    output logic                                   HREADYOUT,
    output logic                                   HRESP,
    // Comparators and pins from outside
    input  wire logic                              SUPPLY_LOW,
    input  wire logic                              MANUAL_RESET_N,
    input  wire logic                              THIRD_SUPPLY_SENSE,
    input  wire logic                              WRITE_PROTECT,
    input  wire logic                              SCL_I,
    input  wire logic                              SDA_I,
    // System reset, both variants
    output logic                                   SYS_RESET_N_O,
    output logic                                   SYS_RESET_N_OE,
    output logic                                   SYS_RESET_HI,
    // Open-drain fault outputs
    output logic                                   WATCHDOG_FAULT_N_O,
    output logic                                   WATCHDOG_FAULT_N_OE,
    output logic                                   THIRD_SUPPLY_FAIL_N_O,
    output logic                                   THIRD_SUPPLY_FAIL_N_OE,
    // Interrupt
    output logic                                   IRQ
);
    import supervisor_pkg::*;

    // Hold-time lookup by select code
    function automatic logic [CNT_W-1:0] hold_lim(input logic [1:0] sel);
        case (sel)
            2'h0:    hold_lim = CNT_W'(HOLD0_CYC);
            2'h1:    hold_lim = CNT_W'(HOLD1_CYC);
            2'h2:    hold_lim = CNT_W'(HOLD2_CYC);
            default: hold_lim = CNT_W'(HOLD3_CYC);
        endcase
    endfunction : hold_lim

    // Watchdog period lookup; off code returns the longest
    function automatic logic [CNT_W-1:0] wd_lim(input logic [1:0] sel);
        case (sel)
            2'h0:    wd_lim = CNT_W'(WD0_CYC);
            2'h1:    wd_lim = CNT_W'(WD1_CYC);
            default: wd_lim = CNT_W'(WD2_CYC);
        endcase
    endfunction : wd_lim

    logic [PIN_W-1:0]  sync1_ff, sync2_ff, sync3_ff, pin_ff, pin_prev_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [EV_W-1:0]   irq_stat_ff, irq_en_ff, ev_set, clr_mask, nxt_stat;
    logic [CNT_W-1:0]  hold_cnt_ff, nxt_hold_cnt, cur_hold_lim;
    logic [CNT_W-1:0]  wd_cnt_ff, cur_wd_lim;
    logic [OFS_W-1:0]  wr_ofs_ff;
    logic [DATA_W-1:0] rd_word;
    wd_seq_t           seq_ff;
    logic              wr_pend_ff, nxt_active, nxt_expired, wd_restart;
    logic              reset_cond, wd_run, addr_ok, wr_ok;
    logic              sda, scl, sda_p, scl_p;
    logic              start_ev, stop_ev, scl_fall, scl_rise;

    // Three-stage synchroniser; a level counts once stages two and three
    // agree, so a single metastable sample never reaches the logic.
    // SDA is sampled only on cycles with CE high, like the other pins.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            sync1_ff    <= PIN_IDLE;
            sync2_ff    <= PIN_IDLE;
            sync3_ff    <= PIN_IDLE;
            pin_ff      <= PIN_IDLE;
            pin_prev_ff <= PIN_IDLE;
        end else if (CE) begin
            sync1_ff    <= {WRITE_PROTECT, THIRD_SUPPLY_SENSE, MANUAL_RESET_N,
                            SUPPLY_LOW, SCL_I, SDA_I};
            sync2_ff    <= sync1_ff;
            sync3_ff    <= sync2_ff;
            pin_ff      <= (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff ^ sync3_ff));
            pin_prev_ff <= pin_ff;
        end
    end

    // Bus condition decode from settled pin levels
    assign sda      = pin_ff[PIN_SDA];
    assign scl      = pin_ff[PIN_SCL];
    assign sda_p    = pin_prev_ff[PIN_SDA];
    assign scl_p    = pin_prev_ff[PIN_SCL];
    assign start_ev = scl & scl_p & sda_p & !sda;
    assign stop_ev  = scl & scl_p & !sda_p & sda;
    assign scl_fall = scl_p & !scl;
    assign scl_rise = !scl_p & scl;

    // Hold counts only while reset stands, so a new hold select never
    // pulls a released reset back; any new cause clears the count
    assign reset_cond   = pin_ff[PIN_LOW] | !pin_ff[PIN_MR_N];
    assign cur_hold_lim = hold_lim(ctrl_ff[CTRL_HOLD_LSB +: 2]);
    always_comb begin
        if (reset_cond) begin
            nxt_hold_cnt = '0;
        end else if (SYS_RESET_HI && hold_cnt_ff < cur_hold_lim) begin
            nxt_hold_cnt = hold_cnt_ff + CNT_W'(1);
        end else begin
            nxt_hold_cnt = hold_cnt_ff;
        end
        nxt_active = reset_cond ||
                     (SYS_RESET_HI && nxt_hold_cnt < cur_hold_lim);
    end

    // Reset starts active, so power-up always runs a full hold
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            hold_cnt_ff    <= '0;
            SYS_RESET_HI   <= 1'b1;
            SYS_RESET_N_OE <= 1'b1;
            SYS_RESET_N_O  <= 1'b0;
        end else if (CE) begin
            hold_cnt_ff    <= nxt_hold_cnt;
            SYS_RESET_HI   <= nxt_active;
            SYS_RESET_N_OE <= nxt_active;
            SYS_RESET_N_O  <= 1'b0;
        end
    end

    // Restart tracker: start, clock low, clock high, stop. Any normal
    // transaction contains that pattern, so it also restarts.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            seq_ff <= WD_IDLE;
        end else if (CE) begin
            if (SYS_RESET_HI) begin
                seq_ff <= WD_IDLE;
            end else if (start_ev) begin
                seq_ff <= WD_START;
            end else begin
                case (seq_ff)
                    WD_START: if (scl_fall) seq_ff <= WD_LOW;
                    WD_LOW:   if (scl_rise) seq_ff <= WD_HIGH;
                    WD_HIGH: begin
                        if (stop_ev) begin
                            seq_ff <= WD_IDLE;
                        end else if (scl_fall) begin
                            seq_ff <= WD_LOW;
                        end
                    end
                    default:  seq_ff <= WD_IDLE;
                endcase
            end
        end
    end
    assign wd_restart = (seq_ff == WD_HIGH) && stop_ev && !SYS_RESET_HI;

    // Watchdog counter; held clear while reset is out or it is off
    assign cur_wd_lim = wd_lim(ctrl_ff[CTRL_WD_LSB +: 2]);
    assign wd_run     = (ctrl_ff[CTRL_WD_LSB +: 2] != WD_OFF) && !nxt_active;
    assign nxt_expired = wd_run && !wd_restart &&
                         (WATCHDOG_FAULT_N_OE ||
                          (wd_cnt_ff == cur_wd_lim - CNT_W'(1)));
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wd_cnt_ff           <= '0;
            WATCHDOG_FAULT_N_OE <= 1'b0;
            WATCHDOG_FAULT_N_O  <= 1'b0;
        end else if (CE) begin
            if (!wd_run || wd_restart || nxt_expired) begin
                wd_cnt_ff <= '0;
            end else begin
                wd_cnt_ff <= wd_cnt_ff + CNT_W'(1);
            end
            WATCHDOG_FAULT_N_OE <= nxt_expired;
            WATCHDOG_FAULT_N_O  <= 1'b0;
        end
    end

    // Third supply fail follows the comparator, no hold applied
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            THIRD_SUPPLY_FAIL_N_OE <= 1'b1;
            THIRD_SUPPLY_FAIL_N_O  <= 1'b0;
        end else if (CE) begin
            THIRD_SUPPLY_FAIL_N_OE <= !pin_ff[PIN_THIRD];
            THIRD_SUPPLY_FAIL_N_O  <= 1'b0;
        end
    end

    // AHB address phase capture; zero wait states, always OKAY
    assign addr_ok = HSEL && HREADY && HTRANS[HTRANS_ACT];
    assign wr_ok   = wr_pend_ff && !pin_ff[PIN_WP];
    always_comb begin
        rd_word = '0;
        case (HADDR[OFS_W-1:0])
            OFS_CTRL:     rd_word = DATA_W'(ctrl_ff);
            OFS_STATUS:   rd_word = DATA_W'({THIRD_SUPPLY_FAIL_N_OE,
                                    WATCHDOG_FAULT_N_OE, SYS_RESET_HI,
                                    pin_ff[PIN_WP], !pin_ff[PIN_MR_N],
                                    pin_ff[PIN_LOW]});
            OFS_IRQ_STAT: rd_word = DATA_W'(irq_stat_ff);
            OFS_IRQ_EN:   rd_word = DATA_W'(irq_en_ff);
            default:      rd_word = '0;   // Clear register reads as zero
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wr_pend_ff <= 1'b0;
            wr_ofs_ff  <= '0;
            HRDATA     <= '0;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
        end else if (CE) begin
            wr_pend_ff <= addr_ok && HWRITE;
            wr_ofs_ff  <= HADDR[OFS_W-1:0];
            if (addr_ok && !HWRITE) begin
                HRDATA <= rd_word;
            end
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
        end
    end

    // Software-written control and enable registers
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl_ff   <= CTRL_RST;
            irq_en_ff <= '0;
        end else if (CE && wr_ok) begin
            if (wr_ofs_ff == OFS_CTRL) begin
                ctrl_ff <= HWDATA[CTRL_W-1:0];
            end
            if (wr_ofs_ff == OFS_IRQ_EN) begin
                irq_en_ff <= HWDATA[EV_W-1:0];
            end
        end
    end

    // Sticky events; a set in the clear cycle wins over the clear
    assign ev_set[EV_RESET] = nxt_active && !SYS_RESET_HI;
    assign ev_set[EV_WDOG]  = nxt_expired && !WATCHDOG_FAULT_N_OE;
    assign ev_set[EV_THIRD] = !pin_ff[PIN_THIRD] && !THIRD_SUPPLY_FAIL_N_OE;
    assign clr_mask = (wr_ok && wr_ofs_ff == OFS_IRQ_CLR) ?
                      HWDATA[EV_W-1:0] : '0;
    assign nxt_stat = (irq_stat_ff & ~clr_mask) | ev_set;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_stat_ff <= '0;
            IRQ         <= 1'b0;
        end else if (CE) begin
            irq_stat_ff <= nxt_stat;
            IRQ         <= |(nxt_stat & irq_en_ff);
        end
    end

    // Checks on the reset outputs and hold sequencing
    chk_reset_od_drive: assert property (@(posedge CLK)
        disable iff (!RESET_N) SYS_RESET_N_OE |-> !SYS_RESET_N_O)
        else $error("open-drain reset drives high");
    chk_reset_pp_match: assert property (@(posedge CLK)
        disable iff (!RESET_N) SYS_RESET_HI == SYS_RESET_N_OE)
        else $error("reset variants disagree");
    chk_cause_asserts: assert property (@(posedge CLK)
        disable iff (!RESET_N) CE && reset_cond |=> SYS_RESET_HI)
        else $error("reset not asserted on cause");
    chk_manual_held: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        CE && !pin_ff[PIN_MR_N] |=> SYS_RESET_HI && hold_cnt_ff == 0)
        else $error("manual reset not holding");
    chk_release_hold: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        $fell(SYS_RESET_HI) |-> hold_cnt_ff == cur_hold_lim &&
        !$past(reset_cond))
        else $error("reset released before hold time");
    chk_hold_restart: assert property (@(posedge CLK)
        disable iff (!RESET_N) CE && reset_cond |=> hold_cnt_ff == 0)
        else $error("hold counter not restarted");

    // Checks on the watchdog, write protect and the other outputs
    chk_por_no_restart: assert property (@(posedge CLK)
        disable iff (!RESET_N) CE && SYS_RESET_HI |=> seq_ff == WD_IDLE)
        else $error("restart during power-on reset");
    chk_restart_clears: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        CE && wd_restart |=> !WATCHDOG_FAULT_N_OE && wd_cnt_ff == 0)
        else $error("restart did not clear watchdog");
    chk_expiry_time: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        $rose(WATCHDOG_FAULT_N_OE) |->
        $past(wd_cnt_ff) == $past(cur_wd_lim) - 1)
        else $error("watchdog fired at wrong count");
    chk_fault_od_drive: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        WATCHDOG_FAULT_N_OE |-> !WATCHDOG_FAULT_N_O && !SYS_RESET_HI)
        else $error("fault pin driven wrongly");
    chk_wp_blocks: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        wr_pend_ff && pin_ff[PIN_WP] |=> $stable(ctrl_ff) && $stable(irq_en_ff))
        else $error("write accepted under protect");
    chk_third_direct: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        CE && pin_ff[PIN_THIRD] |=> !THIRD_SUPPLY_FAIL_N_OE)
        else $error("third fail not following sense");
endmodule : supervisor_reset_watchdog

// File: sim/i2c_host_model.sv
// Behavioural host on the two-wire bus that the supervisor watches.
// Assumes pull-ups on both lines: released lines read high.
`timescale 1ns/1ps
module i2c_host_model #(
    parameter int HALF_NS = 100,
    // Off-edge skew so pin changes never race the sampling clock
    parameter int SKEW_NS = 5
) (
    // Bus lines as seen by the device
    output logic scl,
    output logic sda
);
    // Idle bus: both lines released, link clock stands still
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Start: data falls while clock high, then clock low
    task automatic start_cond();
        sda = 1'b0;
        #(HALF_NS);
        scl = 1'b0;
        #(HALF_NS);
    endtask : start_cond

    // Clock high, then stop: data rises while clock high
    task automatic stop_cond();
        sda = 1'b0;
        #(HALF_NS);
        scl = 1'b1;
        #(HALF_NS);
        sda = 1'b1;
        #(HALF_NS);
    endtask : stop_cond

    // Shortest restart: start, clock low, clock high, stop
    task automatic restart();
        #(SKEW_NS);
        start_cond();
        stop_cond();
    endtask : restart

    // One clocked bit; clock left low afterwards
    task automatic clock_bit(input logic b);
        sda = b;
        #(HALF_NS);
        scl = 1'b1;
        #(HALF_NS);
        scl = 1'b0;
    endtask : clock_bit

    // Full address byte plus released ack slot, then stop
    task automatic write_byte(input logic [7:0] b);
        #(SKEW_NS);
        start_cond();
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i]);
        end
        clock_bit(1'b1);
        stop_cond();
    endtask : write_byte
endmodule : i2c_host_model

// File: sim/tb_supervisor_reset_watchdog.sv
// Self-checking bench for the supervisor block with a bus host model.
// Assumes shortened hold and watchdog counts set below.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    errors++; $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end end
module tb_supervisor_reset_watchdog;
    import supervisor_pkg::*;
    // Short counts keep the run brief; expectations use the same values
    localparam int HOLDS [4] = '{40, 80, 120, 160};
    localparam int WDS   [3] = '{100, 200, 300};
    localparam int LIMIT     = 40000;
    logic        clk = 1'b0, reset_n = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic        ce = 1'b1;
    logic        hreadyout, hresp, scl, sda, irq;
    logic        supply_low = 1'b0, mr_n = 1'b1, third = 1'b1, wp = 1'b0;
    logic        rst_o, rst_oe, rst_hi, wd_o, wd_oe, tf_o, tf_oe;
    int          errors = 0, tests_run = 0, cycles = 0;

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    i2c_host_model i_host (.scl(scl), .sda(sda));

    supervisor_reset_watchdog #(
        .HOLD0_CYC(HOLDS[0]), .HOLD1_CYC(HOLDS[1]), .HOLD2_CYC(HOLDS[2]),
        .HOLD3_CYC(HOLDS[3]), .WD0_CYC(WDS[0]), .WD1_CYC(WDS[1]),
        .WD2_CYC(WDS[2])
    ) i_dut (
        .CLK(clk), .RESET_N(reset_n), .CE(ce), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .SUPPLY_LOW(supply_low),
        .MANUAL_RESET_N(mr_n), .THIRD_SUPPLY_SENSE(third),
        .WRITE_PROTECT(wp), .SCL_I(scl), .SDA_I(sda),
        .SYS_RESET_N_O(rst_o), .SYS_RESET_N_OE(rst_oe),
        .SYS_RESET_HI(rst_hi), .WATCHDOG_FAULT_N_O(wd_o),
        .WATCHDOG_FAULT_N_OE(wd_oe), .THIRD_SUPPLY_FAIL_N_O(tf_o),
        .THIRD_SUPPLY_FAIL_N_OE(tf_oe), .IRQ(irq)
    );

    // Hang guard: a run past the ceiling counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // One AHB-Lite single transfer; waits on ready, no fixed latency
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= 32'(a);
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0, d);
        `CHECK("register read", exp, d)
        `CHECK("bus response", 1'b0, hresp)
    endtask : rd_chk

    // Cycles until reset releases; both pin variants must agree
    task automatic count_release(output int n);
        logic bad = 1'b0;
        n = 0;
        do begin
            @(posedge clk); #1; n++;
            if (rst_oe !== rst_hi || rst_o !== 1'b0) bad = 1'b1;
        end while (rst_hi !== 1'b0 && n < 400);
        `CHECK("reset pin variants", 1'b0, bad)
    endtask : count_release

    task automatic count_fault(output int n);
        n = 0;
        do begin
            @(posedge clk); #1; n++;
        end while (wd_oe !== 1'b1 && n < 400);
    endtask : count_fault

    // Power-up hold, then control register reset value
    task automatic t_power_up();
        int n;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        count_release(n);
        `CHECK("power-up hold", 1'b1, (n >= 40 && n <= 48))
        rd_chk(OFS_CTRL, 32'(CTRL_RST));
    endtask : t_power_up

    // Low supply with every hold select code
    task automatic t_hold_select();
        int n;
        for (int h = 0; h < 4; h++) begin
            wr(OFS_CTRL, 32'((h << 2) | 3));
            supply_low <= 1'b1;
            repeat (10) @(posedge clk); #1;
            `CHECK("low supply reset", 1'b1, rst_hi)
            @(posedge clk);
            supply_low <= 1'b0;
            count_release(n);
            `CHECK("hold", 1'b1, (n >= HOLDS[h] && n <= HOLDS[h] + 8))
        end
    endtask : t_hold_select

    // Manual reset, then a repeat pulse inside the hold time
    task automatic t_manual();
        int n;
        wr(OFS_CTRL, 32'h3);
        mr_n <= 1'b0;
        repeat (60) @(posedge clk); #1;
        `CHECK("manual reset held", 1'b1, rst_hi)
        @(posedge clk);
        mr_n <= 1'b1;
        count_release(n);
        `CHECK("manual hold", 1'b1, (n >= 40 && n <= 48))
        @(posedge clk);
        mr_n <= 1'b0;
        repeat (10) @(posedge clk);
        mr_n <= 1'b1;
        repeat (20) @(posedge clk);
        mr_n <= 1'b0;
        repeat (5) @(posedge clk);
        mr_n <= 1'b1;
        count_release(n);
        `CHECK("hold restart", 1'b1, (n >= 40 && n <= 48))
    endtask : t_manual

    // Each watchdog period, restart kinds, and the off code
    task automatic t_watchdog();
        int m;
        for (int c = 0; c < 3; c++) begin
            wr(OFS_CTRL, 32'(c));
            i_host.restart();
            count_fault(m);
            `CHECK("wd period", 1'b1, (m >= WDS[c] && m <= WDS[c] + 10))
            `CHECK("fault pin", 2'b10, {wd_oe, wd_o})
        end
        wr(OFS_CTRL, 32'h0);
        i_host.write_byte(8'hA6);
        count_fault(m);
        `CHECK("byte restart", 1'b1, (m >= WDS[0] && m <= WDS[0] + 10))
        wr(OFS_CTRL, 32'h3);
        i_host.restart();
        repeat (400) @(posedge clk); #1;
        `CHECK("watchdog off", 1'b0, wd_oe)
    endtask : t_watchdog

    // Third supply fail, interrupt mask and clear, write protect
    task automatic t_irq_wp();
        wr(OFS_IRQ_CLR, 32'h7);
        wr(OFS_IRQ_EN, 32'h4);
        third <= 1'b0;
        repeat (6) @(posedge clk); #1;
        `CHECK("third fail", 2'b10, {tf_oe, tf_o})
        `CHECK("no reset", 1'b0, rst_hi)
        rd_chk(OFS_IRQ_STAT, 32'h4);
        `CHECK("irq raised", 1'b1, irq)
        @(posedge clk);
        third <= 1'b1;
        repeat (6) @(posedge clk); #1;
        `CHECK("third good", 1'b0, tf_oe)
        wr(OFS_IRQ_EN, 32'h0);
        repeat (3) @(posedge clk); #1;
        `CHECK("irq masked", 1'b0, irq)
        wr(OFS_IRQ_EN, 32'h4);
        wp <= 1'b1;
        repeat (6) @(posedge clk);
        wr(OFS_IRQ_CLR, 32'h4);
        wr(OFS_CTRL, 32'h5);
        rd_chk(OFS_IRQ_STAT, 32'h4);
        rd_chk(OFS_CTRL, 32'h3);
        rd_chk(OFS_STATUS, 32'h4);
        wp <= 1'b0;
        repeat (6) @(posedge clk);
        wr(OFS_IRQ_CLR, 32'h4);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk(OFS_IRQ_STAT, 32'h0);
        rd_chk(8'h20, 32'h0);
        rd_chk(OFS_IRQ_CLR, 32'h0);
        `CHECK("irq cleared", 1'b0, irq)
    endtask : t_irq_wp

    // Clock enable low freezes the pin path, then it catches up
    task automatic t_clock_enable();
        ce    <= 1'b0;
        third <= 1'b0;
        repeat (8) @(posedge clk); #1;
        `CHECK("frozen while disabled", 1'b0, tf_oe)
        @(posedge clk);
        ce <= 1'b1;
        repeat (6) @(posedge clk); #1;
        `CHECK("runs when enabled", 1'b1, tf_oe)
        @(posedge clk);
        third <= 1'b1;
        repeat (6) @(posedge clk); #1;
        `CHECK("third good again", 1'b0, tf_oe)
    endtask : t_clock_enable

    // Main sequence
    initial begin
        t_power_up();
        t_hold_select();
        t_manual();
        t_watchdog();
        t_irq_wp();
        t_clock_enable();
        final_report();
    end
endmodule : tb_supervisor_reset_watchdog
